/* File: nmp_cpu_model.sv */
// cpu core model: takes the nmi and irq requests offered to it
module nmp_cpu_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic nmi_req,
    input wire logic irq_req,
    input wire logic accept_en,
    input wire logic [3:0] ack_wait,
    output logic cpu_nmi_ack,
    output logic cpu_irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_ff; // cycles the pending nmi has waited
    // one-cycle acks; the nmi flag is never consulted
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cpu_nmi_ack <= 1'b0;
            cpu_irq_ack <= 1'b0;
            wait_ff <= 4'h0;
        end else begin
            cpu_irq_ack <= irq_req && accept_en && !cpu_irq_ack;
            if (cpu_nmi_ack || !nmi_req || !accept_en) begin
                // idle, or ack just given
                cpu_nmi_ack <= 1'b0;
                wait_ff <= 4'h0;
            end else if (wait_ff >= ack_wait) begin
                cpu_nmi_ack <= 1'b1;
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule

/* File: nmp_pkg.sv */
// Summary of operation
// - nmi detection sets latched flag
// - only software write of zero clears flag
// - flag never gates the nmi request
// - nmi accept drops request, keeps flag
// - flag clear leaves pending nmi intact
// - block levels at or below user mask
// - user mask maximum blocks all but nmi
// - forward needs mask bit clear, above cpu
// - acceptance never alters user mask level
// - reset clears user mask register
// - user mask alone in own page
// - five-bit priority per module source
// - priority values zero and one mask
// - reset clears all priority registers
// - unmasked status shows raw conditions
// - masked status shows only unmasked sources
// - masked modules never reach the cpu
// - reset sets module mask all ones
// - mask clear write ones, reads zero
// - nmi sits at level sixteen
package nmp_pkg;
    // bus and array sizes
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int NUM_SRC = 32;
    localparam int PRI_WORDS = 8;
    localparam int PRI_IDX_W = 3;
    localparam int SRC_IDX_W = 5;
    localparam int PRI_W = 5;
    localparam int LVL_W = 4;
    // byte offsets; user mask alone in the upper 64 kbyte page
    localparam logic [ADDR_W-1:0] OFS_NMI_FLAG = 17'h0_0000;
    localparam logic [ADDR_W-1:0] OFS_PRI_BASE = 17'h0_0040;
    localparam logic [ADDR_W-1:0] OFS_SRC_UNM = 17'h0_0060;
    localparam logic [ADDR_W-1:0] OFS_SRC_MSK = 17'h0_0064;
    localparam logic [ADDR_W-1:0] OFS_MOD_MASK = 17'h0_0068;
    localparam logic [ADDR_W-1:0] OFS_MASK_CLR = 17'h0_006c;
    localparam logic [ADDR_W-1:0] OFS_USER_MASK = 17'h1_0000;
    localparam int PRI_IDX_LSB = 2;
    localparam int PRI_BLK_LSB = 5;
    // field positions
    localparam int NMI_FL_BIT = 0;
    localparam int UMASK_LSB = 4;
    localparam int KEY_LSB = 24;
    localparam logic [7:0] WR_KEY = 8'ha5;
    localparam int SRC_STRIDE = 8;
    // reset values
    localparam logic [LVL_W-1:0] RST_UMASK = 4'h0;
    localparam logic [DATA_W-1:0] RST_MOD_MASK = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] RST_PRI = 32'h0000_0000;
    localparam logic [PRI_W-1:0] PRI_MASK_MAX = 5'h01;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // register selection
    typedef enum logic [2:0] {
        SEL_NONE, SEL_NMI, SEL_UMASK, SEL_PRI, SEL_UNM, SEL_MSK, SEL_MMASK, SEL_MCLR
    } nmp_sel_t;
    // read channel states
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_FETCH = 3'b010,
        RD_RESP = 3'b100
    } nmp_rd_t;
    // address to register, aligned words only
    function automatic nmp_sel_t nmp_decode(input logic [ADDR_W-1:0] a);
        nmp_sel_t s;
        s = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            if (a == OFS_USER_MASK) s = SEL_UMASK;
            else if (a == OFS_NMI_FLAG) s = SEL_NMI;
            else if (a[ADDR_W-1:PRI_BLK_LSB] == OFS_PRI_BASE[ADDR_W-1:PRI_BLK_LSB]) s = SEL_PRI;
            else if (a == OFS_SRC_UNM) s = SEL_UNM;
            else if (a == OFS_SRC_MSK) s = SEL_MSK;
            else if (a == OFS_MOD_MASK) s = SEL_MMASK;
            else if (a == OFS_MASK_CLR) s = SEL_MCLR;
        end
        return s;
    endfunction
    // byte strobes widened to bits
    function automatic logic [DATA_W-1:0] nmp_strb_bits(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
    // strobed merge of write data
    function automatic logic [DATA_W-1:0] nmp_merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] dat, input logic [3:0] strb);
        return (old & ~nmp_strb_bits(strb)) | (dat & nmp_strb_bits(strb));
    endfunction
    // priority field of source i
    function automatic logic [PRI_W-1:0] nmp_pri_of(input logic [PRI_WORDS*DATA_W-1:0] w,
        input int i);
        return w[i*SRC_STRIDE +: PRI_W];
    endfunction
endpackage

/* File: nmp_pri_store.sv */
// priority word store with registered read
module nmp_pri_store
    import nmp_pkg::*;
#(
    parameter int WORDS = PRI_WORDS,
    parameter int IDX_W = PRI_IDX_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [3:0] wr_strb,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [DATA_W-1:0] rd_data,
    output logic [WORDS*DATA_W-1:0] all_words
);
    // whole store state
    typedef struct packed {
        logic [WORDS-1:0][DATA_W-1:0] mem; // priority words
        logic [DATA_W-1:0] rd_data; // read register
    } nmp_store_t;
    nmp_store_t st_ff;
    nmp_store_t nxt_st;

    // strobed write, read capture
    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.mem[wr_idx] = nmp_merge(st_ff.mem[wr_idx], wr_data, wr_strb);
        end
        nxt_st.rd_data = st_ff.mem[rd_idx];
    end

    // registers, all words cleared at reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff.mem <= {WORDS{RST_PRI}};
            st_ff.rd_data <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rd_data;
    assign all_words = st_ff.mem;
endmodule

/* File: nmp_top.sv */
// nmi flag, user mask level, module priority and masking
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
module nmp_top
    import nmp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt sources and cpu side
    input wire logic nmi_detect,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic [LVL_W-1:0] cpu_mask_level,
    input wire logic cpu_nmi_ack,
    input wire logic cpu_irq_ack,
    output logic nmi_req,
    output logic irq_req,
    output logic [PRI_W-1:0] irq_level,
    output logic [SRC_IDX_W-1:0] irq_src
);
    // whole block state
    typedef struct packed {
        logic aw_got; // write address held
        logic [ADDR_W-1:0] aw_addr;
        logic w_got; // write data held
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid; // write response pending
        logic [1:0] bresp;
        nmp_rd_t rd_st; // read channel state
        logic [ADDR_W-1:0] ar_addr;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic nmi_flag; // latched nmi flag
        logic nmi_pend; // nmi request to cpu
        logic [LVL_W-1:0] umask; // user mask level field
        logic [NUM_SRC-1:0] mod_mask; // module mask
        logic irq_req; // forwarded request
        logic [PRI_W-1:0] irq_level;
        logic [SRC_IDX_W-1:0] irq_src;
    } nmp_state_t;
    nmp_state_t st_ff;
    nmp_state_t nxt_st;

    // decode and strobes
    logic do_wr; // both write halves held
    nmp_sel_t wsel; // write target
    nmp_sel_t rsel; // read target
    logic flag_clr_wr; // software clears nmi flag
    logic key_wr; // keyed user mask write
    logic pri_wr; // priority word write
    logic [DATA_W-1:0] pri_rd; // priority word read data
    logic [PRI_WORDS*DATA_W-1:0] pri_words; // all priority fields
    // arbitration
    logic cand_valid;
    logic [PRI_W-1:0] cand_pri;
    logic [SRC_IDX_W-1:0] cand_src;
    logic [PRI_W-1:0] p;

    assign do_wr = st_ff.aw_got && st_ff.w_got;
    assign wsel = nmp_decode(st_ff.aw_addr);
    assign rsel = nmp_decode(st_ff.ar_addr);
    assign pri_wr = do_wr && (wsel == SEL_PRI);
    // zero in the flag bit clears, one is ignored
    assign flag_clr_wr = do_wr && (wsel == SEL_NMI) && st_ff.w_strb[0]
        && !st_ff.w_data[NMI_FL_BIT];
    // key byte and field byte both present and key matches
    assign key_wr = do_wr && (wsel == SEL_UMASK) && st_ff.w_strb[3] && st_ff.w_strb[0]
        && (st_ff.w_data[KEY_LSB +: 8] == WR_KEY);

    // handshake outputs
    assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_arready = (st_ff.rd_st == RD_IDLE);
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = (st_ff.rd_st == RD_RESP);
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign nmi_req = st_ff.nmi_pend;
    assign irq_req = st_ff.irq_req;
    assign irq_level = st_ff.irq_level;
    assign irq_src = st_ff.irq_src;

    // priority words, read at the address handshake
    nmp_pri_store #(
        .WORDS(PRI_WORDS),
        .IDX_W(PRI_IDX_W)
    ) u_store (
        .sys_clk(sys_clk),
        .srst(srst),
        .wr_en(pri_wr),
        .wr_idx(st_ff.aw_addr[PRI_IDX_LSB +: PRI_IDX_W]),
        .wr_data(st_ff.w_data),
        .wr_strb(st_ff.w_strb),
        .rd_idx(s_axi_araddr[PRI_IDX_LSB +: PRI_IDX_W]),
        .rd_data(pri_rd),
        .all_words(pri_words)
    );

    // pick highest unmasked source above both mask levels
    always_comb begin
        cand_valid = 1'b0;
        cand_pri = '0;
        cand_src = '0;
        p = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            p = nmp_pri_of(pri_words, i);
            if (src_req[i] && !st_ff.mod_mask[i]
                && (p > PRI_MASK_MAX)
                && (p[PRI_W-1:1] > st_ff.umask)
                && (p[PRI_W-1:1] > cpu_mask_level)
                && (!cand_valid || (p > cand_pri))) begin
                cand_valid = 1'b1;
                cand_pri = p;
                cand_src = SRC_IDX_W'(i);
            end
        end
    end

    // next state
    always_comb begin
        nxt_st = st_ff;
        // write address and data, either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        // perform the write and raise the response
        if (do_wr) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
            case (wsel)
                SEL_MMASK: begin
                    nxt_st.mod_mask = nmp_merge(st_ff.mod_mask, st_ff.w_data, st_ff.w_strb);
                end
                SEL_MCLR: begin
                    // ones clear mask bits, zeros do nothing
                    nxt_st.mod_mask = st_ff.mod_mask
                        & ~(st_ff.w_data & nmp_strb_bits(st_ff.w_strb));
                end
                default: begin
                end
            endcase
        end else if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // user mask changes only by a keyed write
        if (key_wr) begin
            nxt_st.umask = st_ff.w_data[UMASK_LSB +: LVL_W];
        end
        // read channel
        case (st_ff.rd_st)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    nxt_st.ar_addr = s_axi_araddr;
                    nxt_st.rd_st = RD_FETCH;
                end
            end
            RD_FETCH: begin
                nxt_st.rd_st = RD_RESP;
                nxt_st.rresp = (rsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
                nxt_st.rdata = '0;
                case (rsel)
                    SEL_NMI: nxt_st.rdata[NMI_FL_BIT] = st_ff.nmi_flag;
                    SEL_UMASK: nxt_st.rdata[UMASK_LSB +: LVL_W] = st_ff.umask;
                    SEL_PRI: nxt_st.rdata = pri_rd;
                    SEL_UNM: nxt_st.rdata = src_req;
                    SEL_MSK: nxt_st.rdata = src_req & ~st_ff.mod_mask;
                    SEL_MMASK: nxt_st.rdata = st_ff.mod_mask;
                    default: nxt_st.rdata = '0;
                endcase
            end
            RD_RESP: begin
                if (s_axi_rready) begin
                    nxt_st.rd_st = RD_IDLE;
                end
            end
            default: begin
                nxt_st.rd_st = RD_IDLE;
            end
        endcase
        // nmi flag: detection wins over a clearing write
        if (flag_clr_wr) begin
            nxt_st.nmi_flag = 1'b0;
        end
        if (nmi_detect) begin
            nxt_st.nmi_flag = 1'b1;
        end
        // nmi request, independent of the flag
        if (cpu_nmi_ack) begin
            nxt_st.nmi_pend = 1'b0;
        end
        if (nmi_detect) begin
            nxt_st.nmi_pend = 1'b1;
        end
        // registered maskable request
        nxt_st.irq_req = cand_valid;
        nxt_st.irq_level = cand_pri;
        nxt_st.irq_src = cand_src;
    end

    // state register with reset values
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.rd_st <= RD_IDLE;
            st_ff.umask <= RST_UMASK;
            st_ff.mod_mask <= RST_MOD_MASK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    nmi_flag_set_a: assert property (nmi_detect |=> st_ff.nmi_flag)
        else $error("nmi flag not set after detection");
    nmi_flag_hold_a: assert property (st_ff.nmi_flag && !flag_clr_wr |=> st_ff.nmi_flag)
        else $error("nmi flag cleared without a write");
    nmi_req_set_a: assert property (nmi_detect |=> nmi_req)
        else $error("nmi request missing after detection");
    nmi_keep_a: assert property (nmi_req && !cpu_nmi_ack |=> nmi_req)
        else $error("pending nmi lost before acceptance");
    // flag may already be cleared by software; acceptance must only leave it as it was
    nmi_accept_a: assert property (nmi_req && cpu_nmi_ack && !nmi_detect && !flag_clr_wr
        |=> !nmi_req && st_ff.nmi_flag == $past(st_ff.nmi_flag))
        else $error("nmi accept handling wrong");
    umask_key_a: assert property (!key_wr |=> $stable(st_ff.umask))
        else $error("user mask changed without keyed write");
    umask_accept_a: assert property (cpu_irq_ack && !key_wr |=> $stable(st_ff.umask))
        else $error("user mask changed on acceptance");
    // registered request checked against the mask levels it was chosen under
    irq_gate_a: assert property (irq_req |-> irq_level > PRI_MASK_MAX
        && irq_level[PRI_W-1:1] > $past(st_ff.umask) && irq_level[PRI_W-1:1] > $past(cpu_mask_level))
        else $error("request forwarded at or below a mask level");
    irq_mask_bit_a: assert property (cand_valid |-> !st_ff.mod_mask[cand_src]
        && src_req[cand_src])
        else $error("masked module forwarded");
    irq_umax_a: assert property (st_ff.umask == 4'hf |=> !irq_req)
        else $error("request passed full user mask");
    irq_follow_a: assert property (cand_valid |=> irq_req && irq_src == $past(cand_src)
        && irq_level == $past(cand_pri))
        else $error("forwarded request does not follow selection");
    mclr_read_a: assert property (st_ff.rd_st == RD_FETCH && rsel == SEL_MCLR
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("mask clear register read not zero");
    msk_view_a: assert property (st_ff.rd_st == RD_FETCH && rsel == SEL_MSK
        |=> s_axi_rdata == ($past(src_req) & ~$past(st_ff.mod_mask)))
        else $error("masked status shows masked source");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    nmi_accept_c: cover property (nmi_req && cpu_nmi_ack);
    key_write_c: cover property (key_wr);
    irq_fwd_c: cover property (cand_valid ##1 irq_req);
    mask_clear_c: cover property (do_wr && wsel == SEL_MCLR);
endmodule

/* File: tb.sv */
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
// self-checking bench for the nmi flag, user mask and module priority block
module tb
    import nmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [31:0] pri;
        logic [31:0] msk;
        logic [3:0] ul;
        logic [3:0] cl;
        logic [31:0] src;
        logic er;
        logic [4:0] el;
        logic [4:0] es;
    } nmp_row_t;
    // priority word 0, mask, user level, cpu level, sources, expected request
    nmp_row_t rows [9] = '{
        '{32'h0000_0100, 32'h0000_0000, 4'h0, 4'h0, 32'h0000_0003, 1'b0, 5'h00, 5'h00},
        '{32'h0000_0002, 32'h0000_0000, 4'h0, 4'h0, 32'h0000_0001, 1'b1, 5'h02, 5'h00},
        '{32'h1f00_0010, 32'h0000_0000, 4'h0, 4'h0, 32'h0000_0009, 1'b1, 5'h1f, 5'h03},
        '{32'h1f00_0010, 32'h0000_0008, 4'h0, 4'h0, 32'h0000_0009, 1'b1, 5'h10, 5'h00},
        '{32'h1f00_0010, 32'h0000_0008, 4'h8, 4'h0, 32'h0000_0009, 1'b0, 5'h00, 5'h00},
        '{32'h1f00_0010, 32'h0000_0000, 4'hf, 4'h0, 32'h0000_0009, 1'b0, 5'h00, 5'h00},
        '{32'h1f00_0010, 32'h0000_0008, 4'h7, 4'h8, 32'h0000_0009, 1'b0, 5'h00, 5'h00},
        '{32'h0000_0a0a, 32'h0000_0000, 4'h0, 4'h0, 32'h0000_0003, 1'b1, 5'h0a, 5'h00},
        '{32'h1f00_0010, 32'h0000_0008, 4'h7, 4'h7, 32'h0000_0009, 1'b1, 5'h10, 5'h00}
    };
    logic sys_clk, srst, nmi_detect, cpu_nmi_ack, cpu_irq_ack, nmi_req, irq_req, accept_en;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb, cpu_mask_level, ack_wait;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
    logic [NUM_SRC-1:0] src_req;
    logic [PRI_W-1:0] irq_level;
    logic [SRC_IDX_W-1:0] irq_src;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    nmp_top uut (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .nmi_detect(nmi_detect), .src_req(src_req), .cpu_mask_level(cpu_mask_level),
        .cpu_nmi_ack(cpu_nmi_ack), .cpu_irq_ack(cpu_irq_ack), .nmi_req(nmi_req), .irq_req(irq_req),
        .irq_level(irq_level), .irq_src(irq_src));
    nmp_cpu_model cpu (.sys_clk(sys_clk), .srst(srst), .nmi_req(nmi_req), .irq_req(irq_req),
        .accept_en(accept_en), .ack_wait(ack_wait), .cpu_nmi_ack(cpu_nmi_ack), .cpu_irq_ack(cpu_irq_ack));
    // 100 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end
    // axi4-lite write: address and data together, each released when taken
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_ok;
        logic w_ok;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
                wr_resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask
    // axi4-lite read
    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        logic ar_ok;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar_ok = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (ar_ok && s_axi_rvalid === 1'b1) begin
                rd_data = s_axi_rdata;
                rd_resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (!ar_ok && s_axi_arready === 1'b1) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask
    // user level write with the protection key
    task automatic wr_ulvl(input logic [3:0] lvl);
        axi_wr(OFS_USER_MASK, {WR_KEY, 16'h0000, lvl, 4'h0}, 4'hf);
    endtask
    // waits a bounded time for the nmi request to drop
    task automatic wait_nmi_low();
        repeat (20) begin
            @(posedge sys_clk);
            if (nmi_req === 1'b0) break;
        end
    endtask
    // one nmi detection pulse
    task automatic pulse_nmi();
        @(posedge sys_clk);
        nmi_detect <= 1'b1;
        @(posedge sys_clk);
        nmi_detect <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // main sequence
    initial begin
        {srst, nmi_detect, accept_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h3f & 6'h20;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        cpu_mask_level = 4'h0;
        ack_wait = 4'h2;
        src_req = 32'h0000_0000;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        axi_rd(OFS_USER_MASK);
        `CHK(rd_data, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            axi_rd(OFS_PRI_BASE + ADDR_W'(4 * i));
            `CHK(rd_data, 32'h0000_0000);
        end
        axi_rd(OFS_MOD_MASK);
        `CHK(rd_data, 32'hffff_ffff);
        axi_rd(OFS_NMI_FLAG);
        `CHK(rd_data[0], 1'b0);
        $display("test reset done");
        axi_wr(OFS_USER_MASK, 32'h5a00_0030, 4'hf);
        `CHK(wr_resp, RESP_OKAY);
        axi_rd(OFS_USER_MASK);
        `CHK(rd_data & 32'h0000_00f0, 32'h0000_0000);
        wr_ulvl(4'h3);
        axi_wr(17'h1_0004, 32'ha500_00f0, 4'hf);
        `CHK(wr_resp, RESP_DECERR);
        axi_rd(OFS_USER_MASK);
        `CHK(rd_data & 32'h0000_00f0, 32'h0000_0030);
        axi_rd(17'h1_0004);
        `CHK(rd_resp, RESP_DECERR);
        axi_rd(17'h0_0070);
        `CHK(rd_resp, RESP_DECERR);
        axi_wr(OFS_MASK_CLR, 32'h0000_0005, 4'hf);
        axi_rd(OFS_MOD_MASK);
        `CHK(rd_data, 32'hffff_fffa);
        axi_rd(OFS_MASK_CLR);
        `CHK(rd_data, 32'h0000_0000);
        $display("test user mask and mask clear done");
        foreach (rows[i]) begin
            axi_wr(OFS_PRI_BASE, rows[i].pri, 4'hf);
            axi_wr(OFS_MOD_MASK, rows[i].msk, 4'hf);
            wr_ulvl(rows[i].ul);
            cpu_mask_level <= rows[i].cl;
            src_req <= rows[i].src;
            repeat (3) @(posedge sys_clk);
            `CHK(irq_req, rows[i].er);
            if (rows[i].er) `CHK({irq_level, irq_src}, {rows[i].el, rows[i].es});
            axi_rd(OFS_SRC_UNM);
            `CHK(rd_data, rows[i].src);
            axi_rd(OFS_SRC_MSK);
            `CHK(rd_data, rows[i].src & ~rows[i].msk);
        end
        $display("test priority table done");
        axi_wr(OFS_SRC_UNM, 32'h0000_0000, 4'hf);
        axi_rd(OFS_SRC_UNM);
        `CHK(rd_data, 32'h0000_0009);
        accept_en <= 1'b1;
        repeat (6) @(posedge sys_clk);
        accept_en <= 1'b0;
        axi_rd(OFS_USER_MASK);
        `CHK(rd_data & 32'h0000_00f0, 32'h0000_0070);
        $display("test acceptance done");
        pulse_nmi();
        `CHK(nmi_req, 1'b1);
        axi_rd(OFS_NMI_FLAG);
        `CHK(rd_data[0], 1'b1);
        axi_wr(OFS_NMI_FLAG, 32'h0000_0000, 4'hf);
        axi_rd(OFS_NMI_FLAG);
        `CHK(rd_data[0], 1'b0);
        `CHK(nmi_req, 1'b1);
        wr_ulvl(4'hf);
        repeat (2) @(posedge sys_clk);
        `CHK({nmi_req, irq_req}, 2'b10);
        accept_en <= 1'b1;
        wait_nmi_low();
        `CHK(nmi_req, 1'b0);
        pulse_nmi();
        wait_nmi_low();
        `CHK(nmi_req, 1'b0);
        axi_rd(OFS_NMI_FLAG);
        `CHK(rd_data[0], 1'b1);
        axi_wr(OFS_NMI_FLAG, 32'h0000_0000, 4'hf);
        axi_rd(OFS_NMI_FLAG);
        `CHK(rd_data[0], 1'b0);
        $display("test nmi done");
        // reset in mid run with user level, mask and priority word all set
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        axi_rd(OFS_USER_MASK);
        `CHK(rd_data, 32'h0000_0000);
        axi_rd(OFS_MOD_MASK);
        `CHK(rd_data, 32'hffff_ffff);
        axi_rd(OFS_PRI_BASE);
        `CHK(rd_data, 32'h0000_0000);
        $display("test mid reset done");
        conclude();
    end
endmodule
